// [imr_master.sv]
// I2C master sequencer: start, transmit, receive, acknowledge, stop, bus monitor and arbitration.
//
// Summary of operation
// - Receive request ignored unless unit idle.
// - Receive toggles SCL per rollover, shifts SDA.
// - After eighth clock: store byte, flag, hold SCL.
// - Buffer full set on store, cleared on read.
// - New byte while buffer full sets overflow.
// - Buffer write while busy sets write collision.
// - Acknowledge drives SCL low, SDA from ack value.
// - Acknowledge: period, release SCL, period, low, idle.
// - Stop: SDA low, count, release SCL, SDA.
// - Stop seen: flag, one period later interrupt.
// - Reset returns unit to idle and abandons transfer.
// - Start and stop status cleared when disabled.
// - Stop on busy bus raises interrupt.
// - Released one read back low sets collision.
// - Transmit collision: clear full, release lines.
// - Sequence collision: abort, release, clear requests.
// - After collision, stop on bus raises interrupt.
// - New write restarts byte from first bit.
// - Start with busy lines is a collision.
// - Address ack captured, interrupt after ninth clock.
// - Baud period from reload; tiny reloads invalid.
`timescale 1ns/1ps
module imr_master
	import imr_pkg::*;
(
	input  wire logic              mclk,                  // System clock, 125 MHz.
	input  wire logic              rst_n,                 // Asynchronous reset, active low.
	input  wire logic              clk_en,                // Freezes all state while low.
	input  wire logic              unit_enable,           // Serial unit enable level.
	input  wire logic [DATA_W-1:0] baud_reload,           // Baud counter reload value.
	input  wire logic              start_request_set,     // Pulse: request a Start.
	input  wire logic              stop_request_set,      // Pulse: request a Stop.
	input  wire logic              receive_request_set,   // Pulse: request reception of a byte.
	input  wire logic              ack_sequence_set,      // Pulse: request an acknowledge sequence.
	input  wire logic              ack_value,             // Acknowledge bit to send, 0 is ACK.
	input  wire logic              buf_wr,                // Pulse: write to the data buffer.
	input  wire logic [DATA_W-1:0] buf_wdata,             // Data written to the buffer.
	input  wire logic              buf_rd,                // Pulse: CPU reads the data buffer.
	input  wire logic              irq_clr,               // Pulse: clear the interrupt flag.
	input  wire logic              collision_clr,         // Pulse: clear the bus collision flag.
	input  wire logic              write_collision_clr,              // Pulse: clear the write collision flag.
	input  wire logic              overflow_clr,          // Pulse: clear the receive overflow flag.
	input  wire logic              scl_in,                // SCL line level.
	input  wire logic              sda_in,                // SDA line level.
	output logic                   scl_out,               // SCL drive value, always low.
	output logic                   scl_oe,                // High while pulling SCL low.
	output logic                   sda_out,               // SDA drive value, always low.
	output logic                   sda_oe,                // High while pulling SDA low.
	output logic [DATA_W-1:0]      data_buffer,           // Received data buffer.
	output logic                   buffer_full,           // Buffer holds unread or unsent data.
	output logic                   serial_irq_flag,       // Sticky serial interrupt flag.
	output logic                   receive_overflow,      // Byte arrived while buffer full.
	output logic                   write_collision,       // Buffer write refused.
	output logic                   ack_status,            // Last acknowledge read from slave.
	output logic                   bus_collision_flag,    // Arbitration lost.
	output logic                   start_detected,        // Start seen last on the bus.
	output logic                   stop_detected,         // Stop seen last on the bus.
	output logic                   start_request,         // Start in progress.
	output logic                   stop_request,          // Stop in progress.
	output logic                   receive_request,       // Reception in progress.
	output logic                   ack_sequence_request   // Acknowledge in progress.
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	imr_brg_if brg ();

	imr_state_t        state_reg, state_next;
	logic [DATA_W-1:0] shift_reg, shift_next;
	logic [3:0]        bit_reg, bit_next;
	logic [DATA_W-1:0] data_buffer_reg, data_buffer_next;
	logic              full_reg, full_next;
	logic              irq_reg, irq_next;
	logic              ovf_reg, ovf_next;
	logic              write_collision_reg, write_collision_next;
	logic              ackst_reg, ackst_next;
	logic              bcol_reg, bcol_next;
	logic              sdet_reg, sdet_next;
	logic              pdet_reg, pdet_next;
	logic              scl_hold_reg, scl_hold_next;
	logic              sda_hold_reg, sda_hold_next;
	logic              scl_oe_reg, scl_oe_next;
	logic              sda_oe_reg, sda_oe_next;
	logic              scl_prev_reg, sda_prev_reg;
	logic              pin_low_reg;

	logic              idle_free;
	logic              start_ev;
	logic              stop_ev;
	logic              collide;
	logic              irq_set;
	logic              wait_scl;

	// Values below the minimum make the bus clock too fast to arbitrate, so they are clamped.
	assign brg.reload = (baud_reload < RELOAD_MIN_VALID) ? RELOAD_MIN_VALID : baud_reload;

	imr_baud_gen u_baud (
		.mclk   (mclk),
		.rst_n  (rst_n),
		.clk_en (clk_en),
		.brg    (brg)
	);

	// ----------------------------------------
	// Bus monitor
	// ----------------------------------------
	assign start_ev  = scl_in && scl_prev_reg && sda_prev_reg && !sda_in;
	assign stop_ev   = scl_in && scl_prev_reg && !sda_prev_reg && sda_in;
	assign idle_free = (state_reg == ST_IDLE);

	// High phases stretch: the counter stays loaded until SCL is really high.
	always_comb begin
		wait_scl = 1'b0;
		case (state_reg)
			ST_TX_HIGH, ST_RX_HIGH, ST_ACK_HIGH, ST_STOP_SCL: wait_scl = !scl_in;
			ST_STOP_LOW: wait_scl = sda_in;
			default: wait_scl = 1'b0;
		endcase
	end

	assign brg.run  = (state_reg != ST_IDLE);
	assign brg.load = (state_reg == ST_IDLE) || wait_scl;

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	always_comb begin
		state_next       = state_reg;
		shift_next       = shift_reg;
		bit_next         = bit_reg;
		data_buffer_next = data_buffer_reg;
		full_next        = full_reg;
		ovf_next         = ovf_reg;
		write_collision_next        = write_collision_reg;
		ackst_next       = ackst_reg;
		scl_hold_next    = scl_hold_reg;
		sda_hold_next    = sda_hold_reg;
		sdet_next        = sdet_reg;
		pdet_next        = pdet_reg;
		collide          = 1'b0;
		irq_set          = 1'b0;

		if (start_ev) begin
			sdet_next = 1'b1;
			pdet_next = 1'b0;
		end
		if (stop_ev) begin
			pdet_next = 1'b1;
			sdet_next = 1'b0;
			irq_set   = sdet_reg;
		end
		if (buf_rd) begin
			full_next = 1'b0;
		end

		case (state_reg)
			ST_IDLE: begin
				if (buf_wr) begin
					data_buffer_next = buf_wdata;
					shift_next       = buf_wdata;
					bit_next         = 4'h0;
					full_next        = 1'b1;
					state_next       = ST_TX_LOW;
				end else if (start_request_set) begin
					if (!sda_in || !scl_in) begin
						collide = 1'b1;
					end else begin
						state_next = ST_START_WAIT;
					end
				end else if (receive_request_set) begin
					bit_next   = 4'h0;
					state_next = ST_RX_LOW;
				end else if (ack_sequence_set) begin
					state_next = ST_ACK_LOW;
				end else if (stop_request_set) begin
					state_next = ST_STOP_LOW;
				end
			end
			ST_START_WAIT: begin
				if (!scl_in) begin
					collide = 1'b1;
				end else if (!sda_in || brg.tick) begin
					state_next = ST_START_HOLD;
				end
			end
			ST_START_HOLD: begin
				if (brg.tick) begin
					sda_hold_next = 1'b1;
					scl_hold_next = 1'b0;
					irq_set       = 1'b1;
					state_next    = ST_IDLE;
				end
			end
			ST_TX_LOW: begin
				if (brg.tick) begin
					state_next = ST_TX_HIGH;
				end
			end
			ST_TX_HIGH: begin
				if (scl_in && !sda_in && bit_reg != BIT_ACK_SLOT && shift_reg[DATA_W-1]) begin
					collide = 1'b1;
				end else if (brg.tick) begin
					if (bit_reg == BIT_ACK_SLOT) begin
						ackst_next    = sda_in;
						irq_set       = 1'b1;
						scl_hold_next = 1'b1;
						sda_hold_next = 1'b0;
						state_next    = ST_IDLE;
					end else begin
						full_next  = (bit_reg == BIT_LAST_DATA) ? 1'b0 : full_next;
						shift_next = {shift_reg[DATA_W-2:0], 1'b0};
						bit_next   = bit_reg + 4'h1;
						state_next = ST_TX_LOW;
					end
				end
			end
			ST_RX_LOW: begin
				if (brg.tick) begin
					state_next = ST_RX_HIGH;
				end
			end
			ST_RX_HIGH: begin
				if (brg.tick) begin
					shift_next = {shift_reg[DATA_W-2:0], sda_in};
					bit_next   = bit_reg + 4'h1;
					state_next = ST_RX_LOW;
					if (bit_reg == BIT_LAST_DATA) begin
						data_buffer_next = {shift_reg[DATA_W-2:0], sda_in};
						full_next        = 1'b1;
						ovf_next         = ovf_reg || full_reg;
						irq_set          = 1'b1;
						scl_hold_next    = 1'b1;
						sda_hold_next    = 1'b0;
						state_next       = ST_IDLE;
					end
				end
			end
			ST_ACK_LOW: begin
				if (brg.tick) begin
					state_next = ST_ACK_HIGH;
				end
			end
			ST_ACK_HIGH: begin
				if (scl_in && !sda_in && ack_value) begin
					collide = 1'b1;
				end else if (brg.tick) begin
					scl_hold_next = 1'b1;
					sda_hold_next = 1'b0;
					irq_set       = 1'b1;
					state_next    = ST_IDLE;
				end
			end
			ST_STOP_LOW: begin
				if (brg.tick) begin
					state_next = ST_STOP_SCL;
				end
			end
			ST_STOP_SCL: begin
				if (brg.tick) begin
					state_next = ST_STOP_SDA;
				end
			end
			ST_STOP_SDA: begin
				if (scl_in && sda_in) begin
					pdet_next  = 1'b1;
					sdet_next  = 1'b0;
					state_next = ST_STOP_END;
				end
			end
			ST_STOP_END: begin
				if (brg.tick) begin
					irq_set       = 1'b1;
					scl_hold_next = 1'b0;
					sda_hold_next = 1'b0;
					state_next    = ST_IDLE;
				end
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase

		if (buf_wr && !idle_free) begin
			write_collision_next = 1'b1;
		end else if (write_collision_clr) begin
			write_collision_next = 1'b0;
		end
		if (overflow_clr && !(ovf_next && !ovf_reg)) begin
			ovf_next = 1'b0;
		end

		if (collide) begin
			state_next    = ST_IDLE;
			full_next     = 1'b0;
			scl_hold_next = 1'b0;
			sda_hold_next = 1'b0;
		end

		if (!unit_enable) begin
			state_next    = ST_IDLE;
			scl_hold_next = 1'b0;
			sda_hold_next = 1'b0;
			sdet_next     = 1'b0;
			pdet_next     = 1'b0;
		end
	end

	// Set beats clear on the interrupt and bus collision flags.
	always_comb begin
		irq_next  = irq_set || (irq_reg && !irq_clr);
		bcol_next = collide || (bcol_reg && !collision_clr);
	end

	// Lines are only ever pulled low; releasing a line drops its enable.
	always_comb begin
		scl_oe_next = 1'b0;
		sda_oe_next = 1'b0;
		case (state_next)
			ST_IDLE: begin
				scl_oe_next = scl_hold_next;
				sda_oe_next = sda_hold_next;
			end
			ST_START_HOLD: sda_oe_next = 1'b1;
			ST_TX_LOW, ST_TX_HIGH: begin
				scl_oe_next = (state_next == ST_TX_LOW);
				sda_oe_next = (bit_next != BIT_ACK_SLOT) && !shift_next[DATA_W-1];
			end
			ST_RX_LOW: scl_oe_next = 1'b1;
			ST_ACK_LOW, ST_ACK_HIGH: begin
				scl_oe_next = (state_next == ST_ACK_LOW);
				sda_oe_next = !ack_value;
			end
			ST_STOP_LOW: begin
				scl_oe_next = 1'b1;
				sda_oe_next = 1'b1;
			end
			ST_STOP_SCL: sda_oe_next = 1'b1;
			default: begin
				scl_oe_next = 1'b0;
				sda_oe_next = 1'b0;
			end
		endcase
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg       <= ST_IDLE;
			shift_reg       <= DATA_RESET;
			bit_reg         <= 4'h0;
			data_buffer_reg <= DATA_RESET;
			full_reg        <= 1'b0;
			irq_reg         <= 1'b0;
			ovf_reg         <= 1'b0;
			write_collision_reg        <= 1'b0;
			ackst_reg       <= 1'b0;
			bcol_reg        <= 1'b0;
			sdet_reg        <= 1'b0;
			pdet_reg        <= 1'b0;
			scl_hold_reg    <= 1'b0;
			sda_hold_reg    <= 1'b0;
			scl_oe_reg      <= 1'b0;
			sda_oe_reg      <= 1'b0;
			scl_prev_reg    <= 1'b1;
			sda_prev_reg    <= 1'b1;
			pin_low_reg     <= 1'b0;
		end else if (clk_en) begin
			state_reg       <= state_next;
			shift_reg       <= shift_next;
			bit_reg         <= bit_next;
			data_buffer_reg <= data_buffer_next;
			full_reg        <= full_next;
			irq_reg         <= irq_next;
			ovf_reg         <= ovf_next;
			write_collision_reg        <= write_collision_next;
			ackst_reg       <= ackst_next;
			bcol_reg        <= bcol_next;
			sdet_reg        <= sdet_next;
			pdet_reg        <= pdet_next;
			scl_hold_reg    <= scl_hold_next;
			sda_hold_reg    <= sda_hold_next;
			scl_oe_reg      <= scl_oe_next;
			sda_oe_reg      <= sda_oe_next;
			scl_prev_reg    <= scl_in;
			sda_prev_reg    <= sda_in;
			pin_low_reg     <= 1'b0;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign scl_out              = pin_low_reg;
	assign sda_out              = pin_low_reg;
	assign scl_oe               = scl_oe_reg;
	assign sda_oe               = sda_oe_reg;
	assign data_buffer          = data_buffer_reg;
	assign buffer_full          = full_reg;
	assign serial_irq_flag      = irq_reg;
	assign receive_overflow     = ovf_reg;
	assign write_collision      = write_collision_reg;
	assign ack_status           = ackst_reg;
	assign bus_collision_flag   = bcol_reg;
	assign start_detected       = sdet_reg;
	assign stop_detected        = pdet_reg;
	// Request bits mirror the registered state, so a collision clears them together.
	assign start_request        = (state_reg == ST_START_WAIT) || (state_reg == ST_START_HOLD);
	assign receive_request      = (state_reg == ST_RX_LOW) || (state_reg == ST_RX_HIGH);
	assign ack_sequence_request = (state_reg == ST_ACK_LOW) || (state_reg == ST_ACK_HIGH);
	assign stop_request         = (state_reg == ST_STOP_LOW) || (state_reg == ST_STOP_SCL) ||
	                              (state_reg == ST_STOP_SDA) || (state_reg == ST_STOP_END);

endmodule

// [imr_pkg.sv]
// Shared constants and types for the I2C master receive, acknowledge, stop and arbitration block.
package imr_pkg;

	// ----------------------------------------
	// Widths and counts
	// ----------------------------------------
	localparam int unsigned DATA_W        = 8;
	localparam int unsigned BRG_W         = DATA_W + 1;
	localparam logic [3:0]  BIT_LAST_DATA = 4'h7;
	localparam logic [3:0]  BIT_ACK_SLOT  = 4'h8;

	// ----------------------------------------
	// Baud generator limits and reset values
	// ----------------------------------------
	localparam logic [DATA_W-1:0] RELOAD_MIN_VALID = 8'h03;
	localparam logic [DATA_W-1:0] RELOAD_RESET     = 8'h4f;
	localparam logic [DATA_W-1:0] DATA_RESET       = 8'h00;
	localparam logic [BRG_W-1:0]  BRG_COUNT_RESET  = 9'h000;

	// ----------------------------------------
	// Sequencer states
	// ----------------------------------------
	typedef enum logic [3:0] {
		ST_IDLE,
		ST_START_WAIT,
		ST_START_HOLD,
		ST_TX_LOW,
		ST_TX_HIGH,
		ST_RX_LOW,
		ST_RX_HIGH,
		ST_ACK_LOW,
		ST_ACK_HIGH,
		ST_STOP_LOW,
		ST_STOP_SCL,
		ST_STOP_SDA,
		ST_STOP_END
	} imr_state_t;

endpackage

// [imr_brg_if.sv]
// Interface joining the sequencer to its baud-rate down-counter.
`timescale 1ns/1ps
interface imr_brg_if;
	import imr_pkg::*;

	logic [DATA_W-1:0] reload;
	logic              load;
	logic              run;
	logic              tick;

	modport ctrl (output reload, output load, output run, input tick);
	modport gen  (input reload, input load, input run, output tick);
endinterface

// [imr_baud_gen.sv]
// Reloadable baud-rate down-counter; one tick per baud period.
`timescale 1ns/1ps
module imr_baud_gen
	import imr_pkg::*;
(
	input  wire logic mclk,    // System clock.
	input  wire logic rst_n,   // Asynchronous reset, active low.
	input  wire logic clk_en,  // Freezes the counter while low.
	imr_brg_if.gen    brg      // Control from the sequencer.
);

	logic [BRG_W-1:0] count_reg;
	logic [BRG_W-1:0] count_next;
	logic [BRG_W-1:0] period_top;

	// One baud period is 2*(reload+1) clocks, so that a full bus clock takes 4*(reload+1).
	assign period_top = {brg.reload, 1'b1};
	assign brg.tick   = brg.run && !brg.load && (count_reg == BRG_COUNT_RESET);

	always_comb begin
		count_next = count_reg;
		if (brg.load || brg.tick) begin
			count_next = period_top;
		end else if (brg.run) begin
			count_next = count_reg - BRG_W'(1);
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			count_reg <= BRG_COUNT_RESET;
		end else if (clk_en) begin
			count_reg <= count_next;
		end
	end

endmodule

// [imr_master_props.sv]
// Concurrent checks on the ports of the I2C master block.
`timescale 1ns/1ps
module imr_master_props
	import imr_pkg::*;
(
	input wire logic              mclk,                 // Clock.
	input wire logic              rst_n,                // Reset, active low.
	input wire logic              unit_enable,          // Unit enable.
	input wire logic              ack_value,            // Ack bit.
	input wire logic              buf_wr,               // Buffer write.
	input wire logic              buf_rd,               // Buffer read.
	input wire logic              receive_request_set,  // Receive pulse.
	input wire logic              scl_out,              // SCL value.
	input wire logic              scl_oe,               // SCL pull.
	input wire logic              sda_out,              // SDA value.
	input wire logic              sda_oe,               // SDA pull.
	input wire logic [DATA_W-1:0] data_buffer,          // Buffer.
	input wire logic              buffer_full,          // Full flag.
	input wire logic              serial_irq_flag,      // Interrupt flag.
	input wire logic              receive_overflow,     // Overflow flag.
	input wire logic              write_collision,      // Write collision.
	input wire logic              bus_collision_flag,   // Bus collision.
	input wire logic              start_detected,       // Start seen.
	input wire logic              stop_detected,        // Stop seen.
	input wire logic              start_request,        // Start running.
	input wire logic              stop_request,         // Stop running.
	input wire logic              receive_request,      // Receive running.
	input wire logic              ack_sequence_request  // Ack running.
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);

	// ----------------------------------------
	// Sequences
	// ----------------------------------------
	sequence s_rx_store;
		buffer_full && serial_irq_flag && scl_oe;
	endsequence
	sequence s_ack_drive;
		scl_oe && (sda_oe == !ack_value);
	endsequence
	sequence s_ack_done;
		##[1:600] !ack_sequence_request;
	endsequence

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	AST_OPEN_DRAIN: assert property (!scl_out && !sda_out)
		else $error("bus line driven high");
	AST_RX_REFUSED: assert property (receive_request_set && ack_sequence_request |=> !receive_request)
		else $error("receive taken while busy");
	AST_RX_STORE: assert property ($fell(receive_request) && unit_enable |-> s_rx_store)
		else $error("byte end without store");
	AST_RX_OVERFLOW: assert property ($fell(receive_request) && unit_enable && $past(buffer_full)
		&& !$past(buf_rd) |-> receive_overflow)
		else $error("overflow missed");
	AST_WRITE_COLLISION: assert property (buf_wr && (ack_sequence_request || stop_request)
		|=> write_collision && $stable(data_buffer))
		else $error("busy write not refused");
	AST_ACK_DRIVE: assert property ($rose(ack_sequence_request) |-> s_ack_drive)
		else $error("ack bit not driven");
	AST_ACK_BOUND: assert property ($rose(ack_sequence_request) |-> s_ack_done)
		else $error("ack sequence too long");
	AST_ACK_END: assert property ($fell(ack_sequence_request) && unit_enable && !bus_collision_flag
		|-> scl_oe && serial_irq_flag)
		else $error("ack end wrong");
	AST_STOP_BEGIN: assert property ($rose(stop_request) |-> sda_oe)
		else $error("stop without SDA low");
	AST_STOP_END: assert property ($fell(stop_request) && unit_enable
		|-> stop_detected && serial_irq_flag && !sda_oe && !scl_oe)
		else $error("stop end wrong");
	AST_DISABLE: assert property (!unit_enable |=> !start_detected && !stop_detected && !scl_oe && !sda_oe)
		else $error("disable not honoured");
	AST_COLLISION: assert property ($rose(bus_collision_flag) |-> !scl_oe && !sda_oe && !buffer_full
		&& !start_request && !stop_request && !receive_request && !ack_sequence_request)
		else $error("collision not released");
endmodule

bind imr_master imr_master_props imr_master_props_inst (.mclk, .rst_n, .unit_enable, .ack_value, .buf_wr,
	.buf_rd, .receive_request_set, .scl_out, .scl_oe, .sda_out, .sda_oe, .data_buffer, .buffer_full,
	.serial_irq_flag, .receive_overflow, .write_collision, .bus_collision_flag, .start_detected,
	.stop_detected, .start_request, .stop_request, .receive_request, .ack_sequence_request);

// [imr_slave_model.sv]
// Behavioural I2C slave that sends one byte and may stretch SCL.
`timescale 1ns/1ps
module imr_slave_model (
	input  wire logic       mclk,      // Clock.
	input  wire logic       scl,       // Resolved SCL level.
	input  wire logic       send,      // High while a byte is presented.
	input  wire logic [7:0] tx_byte,   // Byte to send.
	input  wire logic [3:0] stretch,   // SCL hold after each fall.
	output logic            sda_pull,  // Pulls SDA low.
	output logic            scl_pull   // Pulls SCL low.
);
	logic [7:0] sh;
	logic [3:0] hold = 4'h0;
	logic       scl_d = 1'b1;
	logic       seen;

	// A fall only moves to the next bit after a rise, so the fall that opens
	// a reception does not skip the first bit.
	always @(posedge mclk) begin
		scl_d <= scl;
		if (!send) begin
			sh <= tx_byte;
			seen <= 1'b0;
		end else if (scl && !scl_d) begin
			seen <= 1'b1;
		end else if (scl_d && !scl && seen) begin
			sh <= {sh[6:0], 1'b1};
			seen <= 1'b0;
		end
		if (scl_d && !scl)
			hold <= stretch;
		else if (hold != 4'h0)
			hold <= hold - 4'h1;
	end

	assign sda_pull = send && !sh[7];
	assign scl_pull = (hold != 4'h0);
endmodule

// [test_imr_master.sv]
// Self-checking bench for the I2C master with a slave model on the bus.
`timescale 1ns/1ps
module test_imr_master;
	import imr_pkg::*;
	typedef struct {logic [7:0] data; logic [7:0] reload; logic [3:0] stretch; logic ackv;} imr_row_t;

	logic mclk, rst_n, clk_en, unit_enable, ack_value, scl_in, sda_in;
	logic start_request_set, stop_request_set, receive_request_set, ack_sequence_set, buf_wr, buf_rd;
	logic irq_clr, collision_clr, write_collision_clr, overflow_clr, send, tb_scl_low, tb_sda_low, sda_pull, scl_pull;
	logic scl_out, scl_oe, sda_out, sda_oe, buffer_full, serial_irq_flag, receive_overflow, write_collision;
	logic ack_status, bus_collision_flag, start_detected, stop_detected, start_request, stop_request;
	logic receive_request, ack_sequence_request;
	logic [DATA_W-1:0] baud_reload, buf_wdata, data_buffer, tx_byte;
	logic [3:0] stretch;
	int errors;
	int total_checks;
	imr_row_t rows [3] = '{'{8'ha5, 8'h03, 4'h0, 1'b0}, '{8'h3c, 8'h05, 4'h6, 1'b0}, '{8'h96, 8'h00, 4'hb, 1'b1}};

	assign scl_in = !(scl_oe | scl_pull | tb_scl_low);
	assign sda_in = !(sda_oe | sda_pull | tb_sda_low);

	imr_master imr_master_inst (.mclk, .rst_n, .clk_en, .unit_enable, .baud_reload, .start_request_set,
		.stop_request_set, .receive_request_set, .ack_sequence_set, .ack_value, .buf_wr, .buf_wdata, .buf_rd,
		.irq_clr, .collision_clr, .write_collision_clr, .overflow_clr, .scl_in, .sda_in, .scl_out, .scl_oe, .sda_out,
		.sda_oe, .data_buffer, .buffer_full, .serial_irq_flag, .receive_overflow, .write_collision, .ack_status,
		.bus_collision_flag, .start_detected, .stop_detected, .start_request, .stop_request, .receive_request,
		.ack_sequence_request);
	imr_slave_model imr_slave_model_inst (.mclk, .scl(scl_in), .send, .tx_byte, .stretch, .sda_pull, .scl_pull);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task step;
		@(posedge mclk);
		#1;
	endtask
	task automatic pulse(ref logic s);
		s = 1'b1;
		step;
		s = 1'b0;
	endtask
	task check(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask
	task wait_flag(input int sel);
		int n;
		n = 0;
		while (n < 4000 && (sel == 1 ? bus_collision_flag : serial_irq_flag) !== 1'b1) begin
			step;
			n++;
		end
		if (n == 4000) begin
			errors++;
			$display("unexpected at %0t: flag never rose", $time);
		end
	endtask
	task conclude;
		$display("checks %0d, errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// ----------------------------------------
	// Clock, watchdog and tests
	// ----------------------------------------
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	initial begin
		#400000;
		errors++;
		conclude;
	end
	initial begin
		{start_request_set, stop_request_set, receive_request_set, ack_sequence_set, buf_wr, buf_rd} = '0;
		{irq_clr, collision_clr, write_collision_clr, overflow_clr, send, tb_scl_low, tb_sda_low, ack_value} = '0;
		{buf_wdata, tx_byte, stretch} = '0;
		baud_reload = 8'h03;
		clk_en = 1'b1;
		unit_enable = 1'b1;
		rst_n = 1'b0;
		errors = 0;
		total_checks = 0;
		repeat (2) @(posedge mclk);
		#1;
		rst_n = 1'b1;
		check({scl_oe, sda_oe, buffer_full, serial_irq_flag, start_detected, stop_detected, receive_request,
			bus_collision_flag}, 8'h00);
		// The bus is idle after reset, so the unit may claim it.
		pulse(start_request_set);
		wait_flag(0);
		check({start_detected, start_request, sda_oe, 5'h00}, 8'ha0);
		foreach (rows[i]) begin
			baud_reload = rows[i].reload;
			stretch = rows[i].stretch;
			tx_byte = rows[i].data;
			ack_value = rows[i].ackv;
			pulse(irq_clr);
			send = 1'b1;
			pulse(receive_request_set);
			check({receive_request, scl_oe, 6'h00}, 8'hc0);
			wait_flag(0);
			send = 1'b0;
			check(data_buffer, rows[i].data);
			check({buffer_full, receive_request, scl_oe, 5'h00}, 8'ha0);
			pulse(buf_rd);
			check({buffer_full, 7'h00}, 8'h00);
			pulse(irq_clr);
			pulse(ack_sequence_set);
			check({ack_sequence_request, scl_oe, sda_oe, 5'h00}, {2'b11, !rows[i].ackv, 5'h00});
			pulse(receive_request_set);
			check({receive_request, 7'h00}, 8'h00);
			wait_flag(0);
			check({ack_sequence_request, scl_oe, receive_request, 5'h00}, 8'h40);
		end
		baud_reload = 8'h03;
		stretch = 4'h0;
		for (int k = 0; k < 2; k++) begin
			tx_byte = (k == 0) ? 8'h11 : 8'h22;
			pulse(irq_clr);
			send = 1'b1;
			pulse(receive_request_set);
			wait_flag(0);
			send = 1'b0;
		end
		check({receive_overflow, buffer_full, 6'h00}, 8'hc0);
		check(data_buffer, 8'h22);
		pulse(overflow_clr);
		pulse(buf_rd);
		check({receive_overflow, buffer_full, 6'h00}, 8'h00);
		// Another master holds SDA low while all ones are sent.
		tb_sda_low = 1'b1;
		buf_wdata = 8'hff;
		pulse(buf_wr);
		wait_flag(1);
		check({scl_oe, sda_oe, buffer_full, start_request, stop_request, 3'h0}, 8'h00);
		pulse(irq_clr);
		tb_sda_low = 1'b0;
		repeat (3) step;
		check({serial_irq_flag, 7'h00}, 8'h80);
		pulse(collision_clr);
		pulse(irq_clr);
		buf_wdata = 8'h00;
		pulse(buf_wr);
		check({buffer_full, scl_oe, sda_oe, bus_collision_flag, 4'h0}, 8'he0);
		wait_flag(0);
		check({ack_status, buffer_full, 6'h00}, 8'h80);
		pulse(irq_clr);
		pulse(stop_request_set);
		check({stop_request, sda_oe, 6'h00}, 8'hc0);
		buf_wdata = 8'h5a;
		pulse(buf_wr);
		check({write_collision, 7'h00}, 8'h80);
		wait_flag(0);
		check({stop_detected, stop_request, scl_oe, sda_oe, 4'h0}, 8'h80);
		pulse(write_collision_clr);
		unit_enable = 1'b0;
		repeat (2) step;
		check({stop_detected, start_detected, write_collision, 5'h00}, 8'h00);
		unit_enable = 1'b1;
		tb_scl_low = 1'b1;
		pulse(start_request_set);
		check({bus_collision_flag, start_request, 6'h00}, 8'h80);
		tb_scl_low = 1'b0;
		pulse(collision_clr);
		pulse(receive_request_set);
		repeat (2) step;
		rst_n = 1'b0;
		step;
		check({scl_oe, receive_request, 6'h00}, 8'h00);
		rst_n = 1'b1;
		step;
		conclude;
	end
endmodule
